/* sim/srx_regfile_model.sv */
/* Per-link register file model, answering paged window reads.
   Assumes page_req from srx_link_ctrl; data valid while rd is high. */
`timescale 1ns/1ps
module srx_regfile_model import srx_pkg::*; (
	input srx_page_req_t page_req,
	output logic [7:0] page_rdata
);
	logic [7:0] pat;
	// Link tagged pattern, inverted when not read
	assign pat = {page_req.link_sel, page_req.addr[6:0]} ^ 8'h5A;
	assign page_rdata = page_req.rd ? pat : ~pat;
endmodule : srx_regfile_model

/* sim/testbench.sv */
/* Self-checking bench of the receiver link control register bank.
   Assumes srx_pkg and the register file model are compiled first. */
`timescale 1ns/1ps
module testbench import srx_pkg::*;;
	logic clk, rst_n, sp_rvalid, trig, csm, dual, en0, en1;
	srx_sp_req_t req;
	srx_page_req_t page_req;
	logic [7:0] sp_rdata, page_rdata, trim_a, trim_b, d;
	logic [1:0][7:0][7:0] sums;
	srx_cfg_t cfg [2];
	srx_lid_t lid [2];
	int error_cnt = 0;
	int comparisons = 0;
	srx_link_ctrl dut (.clk(clk), .rst_n(rst_n), .sp_req(req), .sp_rdata(sp_rdata),
		.sp_rvalid(sp_rvalid), .page_req(page_req), .page_rdata(page_rdata),
		.cfg_bytes(cfg), .lane_lid(lid), .group_b_termination_cal_trigger(trig),
		.trim_a(trim_a), .trim_b(trim_b), .checksum_mode(csm), .dual_link(dual),
		.link0_enable(en0), .link1_enable(en1), .computed_param_sum(sums));
	srx_regfile_model far_side (.page_req(page_req), .page_rdata(page_rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task close_out();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
		@(posedge clk);
		req.wr <= 1'b0;
		#1;
	endtask : wr
	task rc(input logic [11:0] a, input logic [7:0] exp);
		int n;
		@(posedge clk);
		req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		n = 0;
		while (sp_rvalid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 4) begin
			error_cnt++;
			$display("[FAIL] %0t no read answer", $time);
			close_out();
		end else begin
			chk(sp_rdata, exp);
		end
	endtask : rc
	task t_reset();
		chk(trim_a, 8'hC3);
		chk(trim_b, 8'h93);
		chk({6'h00, en1, en0}, 8'h00);
		rc(12'h2B1, 8'hC3);
		rc(12'h2B2, 8'h93);
		rc(12'h300, 8'h00);
	endtask : t_reset
	task t_trim_cal();
		wr(12'h2B1, 8'hB7);
		wr(12'h2B2, 8'h87);
		chk(trim_a, 8'hB7);
		chk(trim_b, 8'h87);
		rc(12'h2B1, 8'hB7);
		wr(12'h2AE, 8'h01);
		chk({7'h00, trig}, 8'h01);
		wr(12'h2AE, 8'hFF);
		chk({7'h00, trig}, 8'h00);
		rc(12'h2AE, 8'h01);
		wr(12'h2AE, 8'h00);
		chk({7'h00, trig}, 8'h00);
		wr(12'h2AE, 8'h01);
		chk({7'h00, trig}, 8'h01);
	endtask : t_trim_cal
	task t_ctrl();
		for (int i = 0; i < 4; i++) begin
			wr(12'h300, 8'hB8 | 8'(i));
			chk({6'h00, en1, en0}, 8'(i));
			chk({7'h00, dual}, 8'h01);
			rc(12'h300, 8'h08 | 8'(i));
		end
		wr(12'h300, 8'h00);
		chk({7'h00, dual}, 8'h00);
	endtask : t_ctrl
	task t_page();
		for (int p = 0; p < 2; p++) begin
			wr(12'h300, 8'(p << 2));
			rc(12'h300, 8'(p << 2));
			rc(12'h401, {1'(p), 7'h01} ^ 8'h5A);
			rc(12'h47E, {1'(p), 7'h7E} ^ 8'h5A);
			rc(12'h400, 8'h00);
			wr(12'h450, 8'h3C + 8'(p));
			chk({page_req.wr, page_req.rd, 5'h00, page_req.link_sel}, {7'h40, 1'(p)});
			chk(page_req.wdata, 8'h3C + 8'(p));
			chk(page_req.addr[7:0], 8'h50);
			rc(12'h2B2, 8'h87);
		end
	endtask : t_page
	task t_sum();
		wr(12'h300, 8'h40);
		@(posedge clk);
		for (int l = 0; l < 2; l++) begin
			for (int i = 0; i < 11; i++) cfg[l][i] <= 8'h23 + 8'(13 * i + 7 * l);
			for (int n = 0; n < 8; n++) lid[l][n] <= 5'(n + 8 * l);
		end
		repeat (2) @(posedge clk);
		#1;
		chk({7'h00, csm}, 8'h01);
		for (int l = 0; l < 2; l++) begin
			for (int n = 0; n < 8; n++) begin
				d = {cfg[l][2][7:5], lid[l][n]};
				for (int i = 0; i < 11; i++) if (i != 2) d += cfg[l][i];
				chk(sums[l][n], d);
			end
		end
		rc(12'h300, 8'h40);
		wr(12'h300, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		chk({7'h00, csm}, 8'h00);
		for (int l = 0; l < 2; l++) begin
			for (int n = 0; n < 8; n++) begin
				d = cfg[l][0] + cfg[l][1][3:0] + cfg[l][1][7:4] + cfg[l][2][6] + cfg[l][2][5];
				d += lid[l][n] + cfg[l][3][7] + cfg[l][3][4:0] + cfg[l][4] + cfg[l][5][4:0];
				d += cfg[l][6] + cfg[l][7][7:6] + cfg[l][7][4:0] + cfg[l][8][7:5];
				d += cfg[l][8][4:0] + cfg[l][9][7:5] + cfg[l][9][4:0] + cfg[l][10][7];
				d += cfg[l][10][4:0];
				chk(sums[l][n], d);
			end
		end
	endtask : t_sum
	initial begin
		rst_n = 1'b0;
		req = '0;
		cfg = '{default: '0};
		lid = '{default: '0};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_trim_cal();
		t_ctrl();
		t_page();
		t_sum();
		close_out();
	end
endmodule : testbench

/* verilog/srx_consts.svh */
/*
 * Address map, bit positions, reset values and sizes of the receiver
 * link control register bank.
 * Assumes a 12-bit register address and 8-bit data on the serial control port.
 */
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

`define SRX_AW 12
`define SRX_DW 8
`define SRX_LANES 8
`define SRX_LINKS 2
`define SRX_CFG_BYTES 11

`define SRX_ADDR_CAL 12'h2AE
`define SRX_ADDR_TRIM_A 12'h2B1
`define SRX_ADDR_TRIM_B 12'h2B2
`define SRX_ADDR_CTRL 12'h300
`define SRX_PAGE_LO 12'h401
`define SRX_PAGE_HI 12'h47E

`define SRX_CAL_BIT 0
`define SRX_CSUM_BIT 6
`define SRX_MODE_BIT 3
`define SRX_PAGE_BIT 2
`define SRX_EN_LSB 0
`define SRX_EN_MSB 1

`define SRX_TRIM_A_RST 8'hC3
`define SRX_TRIM_B_RST 8'h93

`endif

/* verilog/srx_link_ctrl.sv */
/*
 * Receiver link control register bank: termination calibration trigger,
 * termination trims, checksum method, link mode, link paging and link enables.
 * Assumes a serial control port decoder presents one-cycle wr/rd strobes and
 * the per-link register files answer page_rdata in the same cycle as page_req.
 */
`timescale 1ns/1ps

// Summary of operation
// - Written rising edge starts group B calibration
// - Mode 0: checksum sums individual fields
// - Mode 1: checksum sums packed bytes mod 256
// - Computed checksum placed per lane
// - Bit 3 selects single or dual link
// - Bit 2 steers paged window accesses
// - Page 0 reaches link 0, 1 link 1
// - Enable bit 0 link 0, bit 1 link 1
// - Enable reset 0b00, both links off
// - Encodings 01, 10, 11 enable accordingly
module srx_link_ctrl import srx_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input srx_sp_req_t sp_req,
	output logic [`SRX_DW-1:0] sp_rdata,
	output logic sp_rvalid,
	output srx_page_req_t page_req,
	input wire logic [`SRX_DW-1:0] page_rdata,
	input srx_cfg_t cfg_bytes [`SRX_LINKS],
	input srx_lid_t lane_lid [`SRX_LINKS],
	output logic group_b_termination_cal_trigger,
	output logic [7:0] trim_a,
	output logic [7:0] trim_b,
	output logic checksum_mode,
	output logic dual_link,
	output logic link0_enable,
	output logic link1_enable,
	output logic [`SRX_LINKS-1:0][`SRX_LANES-1:0][7:0] computed_param_sum
);

	srx_state_t st_ff;
	srx_state_t nxt_st;
	logic hit_page;

	// Checksum of one lane, by field or by packed byte
	function automatic logic [7:0] lane_sum(input srx_cfg_t b, input logic [4:0] lid,
		input logic by_bytes);
		logic [7:0] s;
		s = 8'h00;
		if (by_bytes) begin
			for (int i = 0; i < `SRX_CFG_BYTES; i++) begin
				s = (i == 2) ? s + {b[2][7:5], lid} : s + b[i];
			end
		end else begin
			s = b[0] + {4'h0, b[1][3:0]} + {4'h0, b[1][7:4]};
			s = s + {7'h00, b[2][6]} + {7'h00, b[2][5]} + {3'h0, lid};
			s = s + {7'h00, b[3][7]} + {3'h0, b[3][4:0]} + b[4] + {3'h0, b[5][4:0]};
			s = s + b[6] + {6'h00, b[7][7:6]} + {3'h0, b[7][4:0]};
			s = s + {5'h00, b[8][7:5]} + {3'h0, b[8][4:0]};
			s = s + {5'h00, b[9][7:5]} + {3'h0, b[9][4:0]};
			s = s + {7'h00, b[10][7]} + {3'h0, b[10][4:0]};
		end
		return s;
	endfunction : lane_sum

	// Local readback, reserved bits zero
	function automatic logic [7:0] local_rd(input srx_state_t s, input logic [`SRX_AW-1:0] a);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			`SRX_ADDR_CAL: r[`SRX_CAL_BIT] = s.cal_bit;
			`SRX_ADDR_TRIM_A: r = s.trim_a;
			`SRX_ADDR_TRIM_B: r = s.trim_b;
			`SRX_ADDR_CTRL: begin
				r[`SRX_CSUM_BIT] = s.csum_mode;
				r[`SRX_MODE_BIT] = s.link_mode;
				r[`SRX_PAGE_BIT] = s.link_page;
				r[`SRX_EN_MSB:`SRX_EN_LSB] = s.link_en;
			end
			default: r = 8'h00;
		endcase
		return r;
	endfunction : local_rd

	assign hit_page = (sp_req.addr >= `SRX_PAGE_LO) && (sp_req.addr <= `SRX_PAGE_HI);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.cal_start = 1'b0;
		nxt_st.page.wr = 1'b0;
		nxt_st.page.rd = 1'b0;
		nxt_st.rvalid = 1'b0;
		nxt_st.pend_rd = sp_req.rd && hit_page;
		if (sp_req.wr && !hit_page) begin
			unique case (sp_req.addr)
				`SRX_ADDR_CAL: begin
					nxt_st.cal_bit = sp_req.wdata[`SRX_CAL_BIT];
					nxt_st.cal_start = sp_req.wdata[`SRX_CAL_BIT] & ~st_ff.cal_bit;
				end
				`SRX_ADDR_TRIM_A: nxt_st.trim_a = sp_req.wdata;
				`SRX_ADDR_TRIM_B: nxt_st.trim_b = sp_req.wdata;
				`SRX_ADDR_CTRL: begin
					nxt_st.csum_mode = sp_req.wdata[`SRX_CSUM_BIT];
					nxt_st.link_mode = sp_req.wdata[`SRX_MODE_BIT];
					nxt_st.link_page = sp_req.wdata[`SRX_PAGE_BIT];
					nxt_st.link_en = sp_req.wdata[`SRX_EN_MSB:`SRX_EN_LSB];
				end
				default: nxt_st.rvalid = 1'b0;
			endcase
		end
		if (hit_page && (sp_req.wr || sp_req.rd)) begin
			nxt_st.page.wr = sp_req.wr;
			nxt_st.page.rd = sp_req.rd;
			nxt_st.page.link_sel = st_ff.link_page;
			nxt_st.page.addr = sp_req.addr;
			nxt_st.page.wdata = sp_req.wdata;
		end
		if (sp_req.rd && !hit_page) begin
			nxt_st.rdata = local_rd(st_ff, sp_req.addr);
			nxt_st.rvalid = 1'b1;
		end else if (st_ff.pend_rd) begin
			nxt_st.rdata = page_rdata;
			nxt_st.rvalid = 1'b1;
		end
		for (int l = 0; l < `SRX_LINKS; l++) begin
			for (int n = 0; n < `SRX_LANES; n++) begin
				nxt_st.sums[l][n] = lane_sum(cfg_bytes[l], lane_lid[l][n], st_ff.csum_mode);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.trim_a <= `SRX_TRIM_A_RST;
			st_ff.trim_b <= `SRX_TRIM_B_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sp_rdata = st_ff.rdata;
	assign sp_rvalid = st_ff.rvalid;
	assign page_req = st_ff.page;
	assign group_b_termination_cal_trigger = st_ff.cal_start;
	assign trim_a = st_ff.trim_a;
	assign trim_b = st_ff.trim_b;
	assign checksum_mode = st_ff.csum_mode;
	assign dual_link = st_ff.link_mode;
	assign link0_enable = st_ff.link_en[0];
	assign link1_enable = st_ff.link_en[1];
	assign computed_param_sum = st_ff.sums;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_cal_rise;
		sp_req.wr && !hit_page && sp_req.addr == `SRX_ADDR_CAL &&
			sp_req.wdata[`SRX_CAL_BIT] && !st_ff.cal_bit;
	endsequence

	sequence s_page_access;
		hit_page && (sp_req.wr || sp_req.rd);
	endsequence

	sequence s_cal_repeat;
		sp_req.wr && !hit_page && sp_req.addr == `SRX_ADDR_CAL &&
			st_ff.cal_bit;
	endsequence

	sequence s_ctrl_write;
		sp_req.wr && sp_req.addr == `SRX_ADDR_CTRL;
	endsequence

	a_cal_rise_start: assert property (s_cal_rise |=> group_b_termination_cal_trigger ##1
		!group_b_termination_cal_trigger)
		else $error("calibration start missing after rising write");
	a_cal_only_edge: assert property (group_b_termination_cal_trigger |->
		$past(sp_req.wr) && $past(sp_req.addr) == `SRX_ADDR_CAL && !$past(st_ff.cal_bit))
		else $error("calibration start without rising write");
	a_page_route_sel: assert property (s_page_access |=>
		page_req.link_sel == $past(st_ff.link_page) && page_req.addr == $past(sp_req.addr))
		else $error("paged access routed to wrong link");
	a_page_rd_return: assert property (s_page_access ##0 sp_req.rd |=> page_req.rd ##1
		sp_rvalid && sp_rdata == $past(page_rdata))
		else $error("paged read data not returned");
	a_en_reset_off: assert property ($past(!rst_n) |-> !link0_enable && !link1_enable &&
		trim_a == `SRX_TRIM_A_RST && trim_b == `SRX_TRIM_B_RST)
		else $error("reset values wrong");
	a_ctrl_write_fields: assert property (sp_req.wr && sp_req.addr == `SRX_ADDR_CTRL |=>
		dual_link == $past(sp_req.wdata[`SRX_MODE_BIT]) &&
		{link1_enable, link0_enable} == $past(sp_req.wdata[`SRX_EN_MSB:`SRX_EN_LSB]))
		else $error("control fields not taken");
	a_csum_lane_zero: assert property (##1 computed_param_sum[0][0] ==
		lane_sum($past(cfg_bytes[0]), $past(lane_lid[0][0]), $past(checksum_mode)))
		else $error("lane checksum wrong");
	a_reserved_zero: assert property (sp_req.rd && sp_req.addr == `SRX_ADDR_CTRL |=>
		sp_rvalid && sp_rdata[7] == 1'b0 && sp_rdata[5:4] == 2'h0)
		else $error("reserved control bits not zero");
	a_trim_write: assert property (sp_req.wr && sp_req.addr == `SRX_ADDR_TRIM_A |=>
		trim_a == $past(sp_req.wdata))
		else $error("trim write lost");

	// Repeat writes, forwarding, untouched fields, field writes and trim readback
	a_cal_no_repeat: assert property (s_cal_repeat |=> !group_b_termination_cal_trigger)
		else $error("calibration restarted while bit already set");
	a_page_wr_fwd: assert property (s_page_access ##0 sp_req.wr |=> page_req.wr &&
		!page_req.rd && page_req.wdata == $past(sp_req.wdata))
		else $error("paged write not forwarded");
	a_page_keeps_local: assert property (s_page_access |=> $stable(trim_a) &&
		$stable(trim_b) && $stable(dual_link) && $stable(checksum_mode))
		else $error("paged access changed a local register");
	a_ctrl_csum_mode: assert property (s_ctrl_write |=>
		checksum_mode == $past(sp_req.wdata[`SRX_CSUM_BIT]))
		else $error("checksum method not taken");
	a_en_hold: assert property (!sp_req.wr |=> $stable({link1_enable, link0_enable}))
		else $error("link enables changed without a write");
	a_trim_b_write: assert property (sp_req.wr && sp_req.addr == `SRX_ADDR_TRIM_B |=>
		trim_b == $past(sp_req.wdata))
		else $error("second trim write lost");
	a_local_rd_trim: assert property (sp_req.rd && sp_req.addr == `SRX_ADDR_TRIM_B |=>
		sp_rvalid && sp_rdata == $past(trim_b))
		else $error("second trim readback wrong");

endmodule : srx_link_ctrl

/* verilog/srx_pkg.sv */
/*
 * Types of the receiver link control register bank.
 * Assumes srx_consts.svh is on the include path.
 */
`include "srx_consts.svh"

package srx_pkg;

	typedef logic [`SRX_CFG_BYTES-1:0][7:0] srx_cfg_t;
	typedef logic [`SRX_LANES-1:0][4:0] srx_lid_t;

	typedef struct packed {
		logic [`SRX_AW-1:0] addr;
		logic wr;
		logic rd;
		logic [`SRX_DW-1:0] wdata;
	} srx_sp_req_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic link_sel;
		logic [`SRX_AW-1:0] addr;
		logic [`SRX_DW-1:0] wdata;
	} srx_page_req_t;

	typedef struct packed {
		logic cal_bit;
		logic cal_start;
		logic [7:0] trim_a;
		logic [7:0] trim_b;
		logic csum_mode;
		logic link_mode;
		logic link_page;
		logic [1:0] link_en;
		srx_page_req_t page;
		logic pend_rd;
		logic [`SRX_DW-1:0] rdata;
		logic rvalid;
		logic [`SRX_LINKS-1:0][`SRX_LANES-1:0][7:0] sums;
	} srx_state_t;

endpackage : srx_pkg
